// ===== rtl/imsc_pkg.sv
// Package: shared constants and types for the interface mode and strap control link
package imsc_pkg;

  // Nibble codes carried on the link
  localparam logic [3:0] IMSC_START_NIB = 4'h0;
  localparam logic [3:0] IMSC_CYC_GENERAL_READ = 4'h1;
  localparam logic [3:0] IMSC_SYNC_READY = 4'h0;
  localparam logic [3:0] IMSC_IDLE_NIB = 4'hF;
  localparam logic [3:0] IMSC_BOOT_SEL = 4'h0;

  // Field layout of the general input register
  localparam int IMSC_GEN_W = 5;
  localparam int IMSC_BYTE_W = 8;
  localparam int IMSC_LO_LSB = 0;
  localparam int IMSC_HI_LSB = 4;

  // Reset values
  localparam logic [3:0] IMSC_SEL_RST = 4'h0;
  localparam logic [4:0] IMSC_GEN_RST = 5'h00;
  localparam logic [7:0] IMSC_BYTE_RST = 8'h00;

  // Link clock: half period in host clocks (25 MHz / 2 = 12.5 MHz)
  localparam logic [1:0] IMSC_LCLK_HALF = 2'h1;
  // Ticks the host waits for the ready nibble before aborting
  localparam logic [2:0] IMSC_SYNC_WAIT = 3'h4;

  typedef enum logic [3:0] {
    DEV_IDLE,
    DEV_CYC,
    DEV_SEL,
    DEV_TAR_A,
    DEV_TAR_B,
    DEV_SYNC,
    DEV_DAT_LO,
    DEV_DAT_HI,
    DEV_TAR_END
  } imsc_dev_state_type;

  typedef enum logic [3:0] {
    HST_IDLE,
    HST_CYC,
    HST_SEL,
    HST_TAR,
    HST_REL,
    HST_SYNC,
    HST_DAT_LO,
    HST_DAT_HI,
    HST_END_A,
    HST_END_B,
    HST_ABORT
  } imsc_host_state_type;

endpackage

// ===== rtl/imsc_link_if.sv
// Interface: the link wires between the host controller and the flash front end
`timescale 1ns/100ps
interface imsc_link_if;
  logic lclk;
  logic lframe_n;
  logic lreset_n;
  logic cpu_init_n;
  logic [3:0] lad_host;
  logic lad_host_oe_n;
  logic [3:0] lad_dev;
  logic lad_dev_oe_n;
  logic [3:0] lad;

  // Wire level; the pull-up shows as all ones when nobody drives
  assign lad = !lad_host_oe_n ? lad_host : (!lad_dev_oe_n ? lad_dev : 4'hF);

  modport host (
    output lclk,
    output lframe_n,
    output lreset_n,
    output cpu_init_n,
    output lad_host,
    output lad_host_oe_n,
    input lad
  );

  modport dev (
    input lclk,
    input lframe_n,
    input lreset_n,
    input cpu_init_n,
    output lad_dev,
    output lad_dev_oe_n,
    input lad
  );
endinterface

// ===== rtl/imsc_host.sv
// Host end: link clock divider, reset drivers and general input read cycles
`timescale 1ns/100ps
module imsc_host
  import imsc_pkg::*;
(
  input wire logic clk_in,              // 25 MHz host clock
  input wire logic rst_in,              // Async reset, active high
  input wire logic read_req_in,         // Level: start a read, hold until busy
  input wire logic [3:0] target_sel_in, // Strap value of the addressed device
  input wire logic abort_req_in,        // Level: abort the cycle in progress
  input wire logic platform_reset_in,   // Drives the link reset low
  input wire logic cpu_init_in,         // Drives the init reset low
  output logic busy_out,                // Cycle in progress
  output logic done_out,                // One clock pulse, data valid
  output logic error_out,               // One clock pulse, no ready answer
  output logic [7:0] read_data_out,     // Last byte read
  imsc_link_if.host link                // Link side
);

  typedef struct packed {
    logic [1:0] div;
    logic lclk;
    logic lreset_n;
    logic cpu_init_n;
    logic lframe_n;
    logic [3:0] lad;
    logic oe_n;
    imsc_host_state_type st;
    logic [3:0] sel;
    logic [2:0] wait_cnt;
    logic [7:0] data;
    logic done;
    logic error;
  } imsc_host_state_struct_type;

  imsc_host_state_struct_type q, d;
  logic toggle;
  logic tick;

  always_comb begin
    d = q;
    d.done = 1'b0;
    d.error = 1'b0;
    d.lreset_n = !platform_reset_in;
    d.cpu_init_n = !cpu_init_in;
    toggle = (q.div == IMSC_LCLK_HALF - 2'h1);
    // Outputs change on the falling edge so they are stable at the rising edge
    tick = toggle && q.lclk;
    d.div = toggle ? 2'h0 : q.div + 2'h1;
    d.lclk = toggle ? !q.lclk : q.lclk;
    if (tick) begin
      d.lframe_n = 1'b1;
      if (abort_req_in && q.st != HST_IDLE && q.st != HST_ABORT) begin
        d.st = HST_ABORT;
        d.lframe_n = 1'b0;
        d.lad = IMSC_IDLE_NIB;
        d.oe_n = 1'b0;
      end else begin
        case (q.st)
          HST_IDLE: begin
            d.oe_n = 1'b1;
            if (read_req_in) begin
              d.sel = target_sel_in;
              d.lframe_n = 1'b0;
              d.lad = IMSC_START_NIB;
              d.oe_n = 1'b0;
              d.st = HST_CYC;
            end
          end
          HST_CYC: begin
            d.lad = IMSC_CYC_GENERAL_READ;
            d.st = HST_SEL;
          end
          HST_SEL: begin
            d.lad = q.sel;
            d.st = HST_TAR;
          end
          HST_TAR: begin
            d.lad = IMSC_IDLE_NIB;
            d.st = HST_REL;
          end
          HST_REL: begin
            d.oe_n = 1'b1;
            d.wait_cnt = 3'h0;
            d.st = HST_SYNC;
          end
          HST_SYNC: begin
            if (link.lad == IMSC_SYNC_READY) begin
              d.st = HST_DAT_LO;
            end else if (q.wait_cnt == IMSC_SYNC_WAIT - 3'h1) begin
              // Unselected devices never answer; close with an abort
              d.error = 1'b1;
              d.lframe_n = 1'b0;
              d.lad = IMSC_IDLE_NIB;
              d.oe_n = 1'b0;
              d.st = HST_ABORT;
            end else begin
              d.wait_cnt = q.wait_cnt + 3'h1;
            end
          end
          HST_DAT_LO: begin
            d.data[IMSC_LO_LSB +: 4] = link.lad;
            d.st = HST_DAT_HI;
          end
          HST_DAT_HI: begin
            d.data[IMSC_HI_LSB +: 4] = link.lad;
            d.st = HST_END_A;
          end
          HST_END_A: begin
            d.done = 1'b1;
            d.st = HST_END_B;
          end
          HST_END_B: begin
            d.st = HST_IDLE;
          end
          HST_ABORT: begin
            d.oe_n = 1'b1;
            d.st = HST_IDLE;
          end
          default: begin
            d.st = HST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '{div: 2'h0, lclk: 1'b0, lreset_n: 1'b0, cpu_init_n: 1'b0, lframe_n: 1'b1,
             lad: IMSC_IDLE_NIB, oe_n: 1'b1, st: HST_IDLE, sel: IMSC_SEL_RST,
             wait_cnt: 3'h0, data: IMSC_BYTE_RST, done: 1'b0, error: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign link.lclk = q.lclk;
  assign link.lframe_n = q.lframe_n;
  assign link.lreset_n = q.lreset_n;
  assign link.cpu_init_n = q.cpu_init_n;
  assign link.lad_host = q.lad;
  assign link.lad_host_oe_n = q.oe_n;
  assign busy_out = (q.st != HST_IDLE);
  assign done_out = q.done;
  assign error_out = q.error;
  assign read_data_out = q.data;

endmodule // imsc_host

// ===== rtl/imsc_device.sv
// Device end: mode select, reset merge, strap capture and general input read
`timescale 1ns/100ps
module imsc_device
  import imsc_pkg::*;
(
  input wire logic mode_in,                          // Board strap: high for programming mode
  input wire logic [3:0] device_select_straps_in,    // Board straps: identity on the bus
  input wire logic [4:0] general_input_pins_in,      // Board inputs, asynchronous
  input wire logic program_busy_in,                  // Flash core is programming or erasing
  output logic parallel_programming_mode_out,        // Captured mode is programming
  output logic lpc_enable_out,                       // Link interface is operational
  output logic [3:0] device_select_out,              // Captured identity
  output logic boot_device_out,                      // Identity is the boot device
  output logic [4:0] general_input_register_out,     // Filtered general input levels
  output logic internal_reset_out,                   // Merged reset, active high
  output logic program_abort_out,                    // Reset hit a busy program or erase
  output logic read_active_out,                      // Device is in a cycle, from start nibble until it drops to idle
  imsc_link_if.dev link                              // Link side
);

  typedef struct packed {
    logic captured;
    logic parallel_mode;
    logic [3:0] sel;
    logic [4:0] strap_a;
    logic [4:0] strap_b;
    logic [4:0] strap_c;
    logic [2:0] strap_vld;
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    logic [4:0] sync_c;
    logic [4:0] gen_reg;
    imsc_dev_state_type st;
    logic [3:0] lad;
    logic oe_n;
    logic [7:0] data;
  } imsc_dev_state_struct_type;

  imsc_dev_state_struct_type q, d;
  logic reset_any;
  logic link_on;

  // Read cycle as this end sees it, one nibble per rising link clock:
  //   start (frame low, nibble 0), type, strap value, two turnaround rises,
  //   ready, low nibble, high nibble, one turnaround nibble driven high,
  //   then the lines are released again.
  // A strap value that is not ours, or any other type, drops back to idle
  // without ever driving, so several devices can share the lines.
  // Trade-off: the answer byte is taken one rise before ready, so an input
  // that moves during the turnaround is only seen by the next read.
  // In programming mode the link is ignored as a whole.

  // One nibble of the answer byte, low half first on the wire
  function automatic logic [3:0] nib_of(input logic [7:0] b, input logic hi);
    return hi ? b[IMSC_HI_LSB +: 4] : b[IMSC_LO_LSB +: 4];
  endfunction

  // Stage pairs that disagree are still moving; keep the last settled level
  function automatic logic [4:0] settle(input logic [4:0] b, input logic [4:0] c, input logic [4:0] held);
    logic [4:0] r;
    r = held;
    for (int k = 0; k < IMSC_GEN_W; k++) begin
      if (b[k] == c[k]) begin
        r[k] = c[k];
      end
    end
    return r;
  endfunction

  // Either reset pin resets everything; they are merged before any flop sees them
  assign reset_any = !link.lreset_n || !link.cpu_init_n;

  // The link is only served once the mode has been captured as LPC
  assign link_on = q.captured && !q.parallel_mode;

  always_comb begin
    d = q;

    // Straps pass three stages like any pin; capture waits until the stages are full and the second and third agree
    d.strap_a = {mode_in, device_select_straps_in};
    d.strap_b = q.strap_a;
    d.strap_c = q.strap_b;
    d.strap_vld = {q.strap_vld[1:0], 1'b1};
    if (!q.captured && q.strap_vld[2] && (q.strap_b == q.strap_c)) begin
      d.captured = 1'b1;
      d.parallel_mode = q.strap_c[4];
      d.sel = q.strap_c[3:0];
    end


    // Three stages; a change counts once the second and third agree
    d.sync_a = general_input_pins_in;
    d.sync_b = q.sync_a;
    d.sync_c = q.sync_b;
    d.gen_reg = settle(q.sync_b, q.sync_c, q.gen_reg);

    case (q.st)
      DEV_IDLE: begin
        d.st = DEV_IDLE;
      end
      DEV_CYC: begin
        d.st = (link.lad == IMSC_CYC_GENERAL_READ) ? DEV_SEL : DEV_IDLE;
      end
      DEV_SEL: begin
        // Another device owns cycles with a different strap value
        d.st = (link.lad == q.sel) ? DEV_TAR_A : DEV_IDLE;
      end
      DEV_TAR_A: begin
        d.st = DEV_TAR_B;
      end
      DEV_TAR_B: begin
        // Byte taken here, half a link clock after the host released the lines
        d.data = {{(IMSC_BYTE_W - IMSC_GEN_W){1'b0}}, q.gen_reg};
        d.st = DEV_SYNC;
      end
      DEV_SYNC: begin
        d.st = DEV_DAT_LO;
      end
      DEV_DAT_LO: begin
        d.st = DEV_DAT_HI;
      end
      DEV_DAT_HI: begin
        d.st = DEV_TAR_END;
      end
      DEV_TAR_END: begin
        d.st = DEV_IDLE;
      end
      default: begin
        d.st = DEV_IDLE;
      end
    endcase

    // Frame low overrides any state: a start nibble begins a cycle, anything else aborts
    if (!link.lframe_n) begin
      d.st = (link.lad == IMSC_START_NIB) ? DEV_CYC : DEV_IDLE;
    end

    if (!link_on) begin
      d.st = DEV_IDLE;
    end

    // Drivers are registered so they change only on the rising edge or at reset
    d.oe_n = 1'b0;
    case (d.st)
      DEV_SYNC: begin
        d.lad = IMSC_SYNC_READY;
      end
      DEV_DAT_LO: begin
        d.lad = nib_of(d.data, 1'b0);
      end
      DEV_DAT_HI: begin
        d.lad = nib_of(d.data, 1'b1);
      end
      DEV_TAR_END: begin
        d.lad = IMSC_IDLE_NIB;
      end
      default: begin
        d.lad = IMSC_IDLE_NIB;
        d.oe_n = 1'b1;
      end
    endcase
  end

  // Reset release is asynchronous to the link clock. Nothing answers on the link
  // until the straps are captured four rises later, so a first edge cut short by
  // the release cannot start a cycle.
  always_ff @(posedge link.lclk or posedge reset_any) begin
    if (reset_any) begin
      // Drivers released and read state dropped at once
      q <= '{captured: 1'b0, parallel_mode: 1'b0, sel: IMSC_SEL_RST,
             strap_a: {1'b0, IMSC_SEL_RST}, strap_b: {1'b0, IMSC_SEL_RST}, strap_c: {1'b0, IMSC_SEL_RST},
             strap_vld: 3'h0,
             sync_a: IMSC_GEN_RST, sync_b: IMSC_GEN_RST, sync_c: IMSC_GEN_RST,
             gen_reg: IMSC_GEN_RST, st: DEV_IDLE, lad: IMSC_IDLE_NIB,
             oe_n: 1'b1, data: IMSC_BYTE_RST};
    end else begin
      q <= d;
    end
  end

  assign link.lad_dev = q.lad;
  assign link.lad_dev_oe_n = q.oe_n;

  assign parallel_programming_mode_out = q.captured && q.parallel_mode;
  assign lpc_enable_out = link_on;
  assign device_select_out = q.sel;
  assign boot_device_out = q.captured && (q.sel == IMSC_BOOT_SEL);
  assign general_input_register_out = q.gen_reg;
  assign internal_reset_out = reset_any;
  // Core must stop programming or erasing on this; contents may be left invalid
  assign program_abort_out = reset_any && program_busy_in;
  assign read_active_out = (q.st != DEV_IDLE);

endmodule // imsc_device

// ===== dv/imsc_props.sv
// Checker: link properties seen at the device end
`timescale 1ns/100ps
module imsc_props
  import imsc_pkg::*;
(
  input wire logic rst_in, // Host reset
  input wire logic lclk, // Link clock
  input wire logic lframe_n, // Frame, active low
  input wire logic lreset_n, // Link reset
  input wire logic cpu_init_n, // Init reset
  input wire logic lad_dev_oe_n, // Device enable
  input wire logic [3:0] lad // Wire level
);
  default clocking @(posedge lclk); endclocking
  // A device reset cuts a cycle short, so only the reset checks look through it
  default disable iff (rst_in || !lreset_n || !cpu_init_n);
  sequence start_s;
    !lframe_n && lad == IMSC_START_NIB;
  endsequence
  sequence burst_s;
    !lad_dev_oe_n [*3] ##1 !lad_dev_oe_n && lad == IMSC_IDLE_NIB ##1 lad_dev_oe_n;
  endsequence
  rst_hiz_a: assert property (disable iff (rst_in) !lreset_n |-> lad_dev_oe_n)
    else $error("Device drives in link reset");
  init_hiz_a: assert property (disable iff (rst_in) !cpu_init_n |-> lad_dev_oe_n)
    else $error("Device drives in init reset");
  no_early_a: assert property (start_s |=> lad_dev_oe_n [*4])
    else $error("Device drives before turnaround");
  start_slot_a: assert property ($fell(lad_dev_oe_n) |-> $past(!lframe_n && lad == IMSC_START_NIB, 5))
    else $error("Device drive not tied to start");
  type_slot_a: assert property ($fell(lad_dev_oe_n) |-> $past(lad, 4) == IMSC_CYC_GENERAL_READ && lad == IMSC_SYNC_READY)
    else $error("Drive without read type or ready");
  burst_len_a: assert property ($fell(lad_dev_oe_n) |-> burst_s)
    else $error("Device drive length wrong");
  hi_zero_a: assert property ($fell(lad_dev_oe_n) |-> ##2 lad[3:1] == 3'h0)
    else $error("High nibble upper bits set");
  abort_idle_a: assert property (!lframe_n && lad != IMSC_START_NIB |=> lad_dev_oe_n [*2])
    else $error("Device drives after abort");
endmodule // imsc_props

// ===== dv/testbench.sv
// Testbench: host and device ends joined over the link
`timescale 1ns/100ps
module testbench;
  import imsc_pkg::*;
  logic clk_in = 1'b0, rst_in = 1'b1, read_req_in = 1'b0, abort_req_in = 1'b0;
  logic platform_reset_in = 1'b0, cpu_init_in = 1'b0, mode_in = 1'b0, program_busy_in = 1'b0;
  logic [3:0] target_sel_in = 4'h0, device_select_straps_in = 4'h0, device_select_out;
  logic [4:0] general_input_pins_in = 5'h00, general_input_register_out;
  logic busy_out, done_out, error_out, parallel_programming_mode_out, lpc_enable_out;
  logic boot_device_out, internal_reset_out, program_abort_out, read_active_out;
  logic [7:0] read_data_out;
  logic [31:0] seed = 32'h23;
  logic [1:0] res;
  int err_total = 0;
  int n_compared = 0;
  imsc_link_if link();
  imsc_host imsc_host_i (.clk_in, .rst_in, .read_req_in, .target_sel_in, .abort_req_in,
    .platform_reset_in, .cpu_init_in, .busy_out, .done_out, .error_out, .read_data_out, .link);
  imsc_device imsc_device_i (.mode_in, .device_select_straps_in, .general_input_pins_in,
    .program_busy_in, .parallel_programming_mode_out, .lpc_enable_out, .device_select_out,
    .boot_device_out, .general_input_register_out, .internal_reset_out, .program_abort_out,
    .read_active_out, .link);
  imsc_props imsc_props_i (.rst_in, .lclk(link.lclk), .lframe_n(link.lframe_n),
    .lreset_n(link.lreset_n), .cpu_init_n(link.cpu_init_n), .lad_dev_oe_n(link.lad_dev_oe_n),
    .lad(link.lad));
  always #20 clk_in = ~clk_in;
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic [7:0] exp_byte(logic [4:0] g);
    return {3'h0, g};
  endfunction
  task tk(int n);
    repeat (n) @(posedge clk_in);
  endtask
  task chk(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task test_done();
    $display("Compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task expire();
    $display("Error wait expected event seen timeout");
    err_total++;
    test_done();
  endtask
  task start_read(logic [3:0] s);
    int i;
    @(posedge clk_in);
    target_sel_in <= s;
    read_req_in <= 1'b1;
    for (i = 0; i < 40 && busy_out !== 1'b1; i++) @(negedge clk_in);
    if (i == 40) expire();
    @(posedge clk_in);
    read_req_in <= 1'b0;
  endtask
  // Collects done and error pulses until the host is idle again
  task wait_end();
    int i;
    res = 2'h0;
    for (i = 0; i < 60 && busy_out !== 1'b0; i++) begin
      @(negedge clk_in);
      res = res | {error_out, done_out};
    end
    if (i == 60) expire();
  endtask
  task do_read(logic [3:0] s);
    start_read(s);
    wait_end();
  endtask
  // Straps and mode may only move while the device is held in reset
  task dev_reset(logic m, logic [3:0] s);
    @(posedge clk_in);
    platform_reset_in <= 1'b1;
    tk(4);
    mode_in <= m;
    device_select_straps_in <= s;
    tk(4);
    platform_reset_in <= 1'b0;
    tk(12);
    @(negedge clk_in);
    chk("mode", 8'(m), 8'(parallel_programming_mode_out));
    chk("lpc", 8'(!m), 8'(lpc_enable_out));
    chk("sel", 8'(s), 8'(device_select_out));
    chk("boot", 8'(s == IMSC_BOOT_SEL), 8'(boot_device_out));
  endtask
  initial begin
    int i;
    logic [3:0] s;
    logic [4:0] g;
    tk(3);
    rst_in <= 1'b0;
    for (int j = 0; j < 3; j++) begin
      s = (j == 0) ? IMSC_BOOT_SEL : 4'(rnd());
      dev_reset(1'b0, s);
      for (i = 0; i < 4; i++) begin
        g = 5'(rnd());
        general_input_pins_in <= g;
        tk(8);
        do_read(s);
        chk("result", 8'h01, 8'(res));
        chk("data", exp_byte(g), read_data_out);
        chk("greg", 8'(g), 8'(general_input_register_out));
        chk("lad", 8'(IMSC_IDLE_NIB), 8'(link.lad));
        chk("frame", 8'h01, 8'(link.lframe_n));
      end
      do_read(s + 4'h1);
      chk("other", 8'h02, 8'(res));
      $display("Test straps %h done", s);
    end
    start_read(s);
    tk(2);
    abort_req_in <= 1'b1;
    tk(2);
    abort_req_in <= 1'b0;
    wait_end();
    chk("abort", 8'h00, 8'(res));
    do_read(s);
    chk("after abort", 8'h01, 8'(res));
    $display("Test abort done");
    for (i = 0; i < 2; i++) begin
      start_read(s);
      program_busy_in <= 1'b1;
      tk(10);
      @(negedge clk_in);
      chk("active", 8'h01, 8'(read_active_out));
      @(posedge clk_in);
      cpu_init_in <= (i == 0);
      platform_reset_in <= (i == 1);
      tk(3);
      @(negedge clk_in);
      chk("reset", 8'h01, 8'(internal_reset_out));
      chk("oe", 8'h01, 8'(link.lad_dev_oe_n));
      chk("active", 8'h00, 8'(read_active_out));
      chk("pabort", 8'h01, 8'(program_abort_out));
      @(posedge clk_in);
      cpu_init_in <= 1'b0;
      platform_reset_in <= 1'b0;
      program_busy_in <= 1'b0;
      wait_end();
      chk("pabort idle", 8'h00, 8'(program_abort_out));
      tk(12);
      do_read(s);
      chk("recover", 8'h01, 8'(res));
      chk("recover data", exp_byte(g), read_data_out);
    end
    $display("Test reset done");
    dev_reset(1'b1, s);
    do_read(s);
    chk("pp read", 8'h02, 8'(res));
    dev_reset(1'b0, s);
    $display("Test mode done");
    test_done();
  end
endmodule // testbench
